/* File: core/csm_top.sv */
// Purpose: Blade-side ownership of the shared console and media tray
// Assumes: Messages are framed elsewhere; commands and report answers arrive
//          as one-cycle strobes on this clock
//
// The address map and register access over Wishbone are this design's own decisions.
`default_nettype none

module csm_top
   import csm_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES
)(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Front-panel buttons
   input wire logic i_console_button,
   input wire logic i_media_button,
   // Selection command from the manager
   input wire logic i_cmd_valid,
   input wire csm_sel_type i_cmd_sel,
   output logic o_cmd_resp,
   output csm_sel_type o_resp_sel,
   // Selection report to the manager
   output logic o_rpt_valid,
   output csm_report_type o_rpt,
   input wire logic i_rpt_ack,
   // Resource paths and indicators
   output logic o_console_enable,
   output logic o_media_enable,
   output logic o_console_led,
   output logic o_media_led
);

   // Registers
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic enable_ff;
   logic [12:0] hold_ms_ff;
   csm_sel_type own_ff;
   csm_sel_type path_ff;
   csm_sel_type want_ff;
   csm_sel_type rel_mask_ff;
   logic rel_busy_ff;
   logic [12:0] rel_cnt_ff;
   logic rel_pend_ff;
   logic req_pend_ff;
   logic [15:0] tick_cnt_ff;
   logic tick_ff;
   csm_rpt_state_type state_ff;
   logic rpt_valid_ff;
   csm_report_type rpt_ff;
   logic cmd_resp_ff;
   csm_sel_type resp_sel_ff;

   // Next values and decode
   wire logic [1:0] press;
   wire logic wb_req;
   wire logic wb_wr;
   wire logic hit_ctrl;
   wire logic hit_hold;
   wire logic hit_stat;
   wire logic [12:0] wr_hold;
   wire logic [31:0] nxt_rdat;
   wire csm_sel_type grant;
   wire csm_sel_type desel;
   wire csm_sel_type new_press;
   wire logic release_now;
   wire logic launch_rel;
   wire logic launch_req;
   csm_sel_type nxt_own;
   csm_sel_type nxt_path;
   csm_sel_type nxt_want;
   csm_sel_type nxt_rel_mask;
   logic nxt_rel_busy;
   logic [12:0] nxt_rel_cnt;
   csm_rpt_state_type nxt_state;
   logic nxt_rpt_valid;
   csm_report_type nxt_rpt;

   // Button synchronisers
   csm_button_edge u_console_btn (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_button(i_console_button),
      .o_press(press[0])
   );
   csm_button_edge u_media_btn (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_button(i_media_button),
      .o_press(press[1])
   );

   // Bus decode; one wait state, writes land on the ack edge
   assign wb_req = i_wb_cyc & i_wb_stb & ~ack_ff;
   assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & ack_ff;
   assign hit_ctrl = (i_wb_adr[7:2] == CTRL_OFS[7:2]);
   assign hit_hold = (i_wb_adr[7:2] == HOLD_OFS[7:2]);
   assign hit_stat = (i_wb_adr[7:2] == STATUS_OFS[7:2]);
   assign wr_hold = (i_wb_dat[12:0] > HOLD_MAX_MS) ? HOLD_MAX_MS :
                    i_wb_dat[12:0];
   assign nxt_rdat = hit_ctrl ? {31'h0000_0000, enable_ff} :
      hit_hold ? {19'h0_0000, hold_ms_ff} :
      hit_stat ? {24'h00_0000, rel_busy_ff, (state_ff == RPT_SEND),
                  want_ff, path_ff, own_ff} :
      32'h0000_0000;

   // Command decode: a one grants, a zero on an owned bit deselects
   assign grant = i_cmd_valid ? i_cmd_sel : 2'b00;
   assign desel = i_cmd_valid ? (own_ff & ~i_cmd_sel) : 2'b00;
   // Presses only count for resources not yet owned
   assign new_press = enable_ff ? (press & ~own_ff) : 2'b00;

   // Release falls due when the hold count runs out
   assign release_now = rel_busy_ff & (rel_cnt_ff == 13'h0000);
   // Notices go ahead of requests
   assign launch_rel = (state_ff == RPT_IDLE) & rel_pend_ff;
   assign launch_req = (state_ff == RPT_IDLE) & ~rel_pend_ff & req_pend_ff;

   // Ownership, path and want flags
   always_comb begin
      nxt_own = (own_ff | grant) & ~desel;
      nxt_path = path_ff | grant;
      if (release_now) begin
         nxt_path = nxt_path & ~rel_mask_ff;
      end
      nxt_want = (want_ff & ~grant) | new_press;
   end

   // Release hold timer, loaded by each deselect
   always_comb begin
      nxt_rel_mask = (rel_mask_ff & ~grant) | desel;
      nxt_rel_busy = rel_busy_ff;
      nxt_rel_cnt = rel_cnt_ff;
      if (release_now) begin
         nxt_rel_mask = desel;
         nxt_rel_busy = 1'b0;
      end else if (rel_busy_ff && tick_ff) begin
         nxt_rel_cnt = rel_cnt_ff - 13'h0001;
      end
      if (desel != 2'b00) begin
         nxt_rel_busy = 1'b1;
         nxt_rel_cnt = hold_ms_ff;
      end
   end

   // Report channel
   always_comb begin
      nxt_state = state_ff;
      nxt_rpt_valid = rpt_valid_ff;
      nxt_rpt = rpt_ff;
      case (state_ff)
         RPT_IDLE: begin
            if (launch_rel) begin
               nxt_rpt = '{kind: RPT_NOTICE, sel: path_ff};
               nxt_rpt_valid = 1'b1;
               nxt_state = RPT_SEND;
            end else if (launch_req) begin
               nxt_rpt = '{kind: RPT_REQUEST, sel: own_ff | want_ff};
               nxt_rpt_valid = 1'b1;
               nxt_state = RPT_SEND;
            end
         end
         RPT_SEND: begin
            if (i_rpt_ack) begin
               nxt_rpt_valid = 1'b0;
               nxt_state = RPT_IDLE;
            end
         end
         default: begin
            nxt_rpt_valid = 1'b0;
            nxt_state = RPT_IDLE;
         end
      endcase
   end

   // Bus registers
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
         enable_ff <= CTRL_ENABLE_RST;
         hold_ms_ff <= HOLD_RST;
      end else begin
         ack_ff <= wb_req;
         rdat_ff <= wb_req ? nxt_rdat : 32'h0000_0000;
         if (wb_wr && hit_ctrl && i_wb_sel[0]) begin
            enable_ff <= i_wb_dat[CTRL_ENABLE_BIT];
         end
         if (wb_wr && hit_hold && (i_wb_sel[1:0] == 2'b11)) begin
            hold_ms_ff <= wr_hold;
         end
      end
   end

   // Millisecond tick divider
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (tick_cnt_ff == 16'(TICK_LEN - 1));
         tick_cnt_ff <= (tick_cnt_ff == 16'(TICK_LEN - 1)) ? 16'h0000 :
                        tick_cnt_ff + 16'h0001;
      end
   end

   // Ownership and release state
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         own_ff <= 2'b00;
         path_ff <= 2'b00;
         want_ff <= 2'b00;
         rel_mask_ff <= 2'b00;
         rel_busy_ff <= 1'b0;
         rel_cnt_ff <= 13'h0000;
         rel_pend_ff <= 1'b0;
         req_pend_ff <= 1'b0;
      end else begin
         own_ff <= nxt_own;
         path_ff <= nxt_path;
         want_ff <= nxt_want;
         rel_mask_ff <= nxt_rel_mask;
         rel_busy_ff <= nxt_rel_busy;
         rel_cnt_ff <= nxt_rel_cnt;
         // A new event wins over the launch that clears it
         rel_pend_ff <= (rel_pend_ff & ~launch_rel) | release_now;
         req_pend_ff <= (req_pend_ff & ~launch_req) |
                        (new_press != 2'b00);
      end
   end

   // Report and command answer outputs
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= RPT_IDLE;
         rpt_valid_ff <= 1'b0;
         rpt_ff <= '0;
         cmd_resp_ff <= 1'b0;
         resp_sel_ff <= 2'b00;
      end else begin
         state_ff <= nxt_state;
         rpt_valid_ff <= nxt_rpt_valid;
         rpt_ff <= nxt_rpt;
         cmd_resp_ff <= i_cmd_valid;
         resp_sel_ff <= i_cmd_valid ? nxt_own : resp_sel_ff;
      end
   end

   // Port drive
   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;
   assign o_cmd_resp = cmd_resp_ff;
   assign o_resp_sel = resp_sel_ff;
   assign o_rpt_valid = rpt_valid_ff;
   assign o_rpt = rpt_ff;
   assign o_console_enable = path_ff.console_select_bit;
   assign o_media_enable = path_ff.media_tray_select_bit;
   assign o_console_led = own_ff.console_select_bit;
   assign o_media_led = own_ff.media_tray_select_bit;

   // Checks on the handshake
   property p_path_needs_grant;
      @(posedge i_clock) disable iff (!i_rst_n)
      $rose(path_ff.console_select_bit) |->
         $past(i_cmd_valid && i_cmd_sel.console_select_bit);
   endproperty
   a_path_needs_grant: assert property (p_path_needs_grant)
      else $error("console path opened without grant");

   property p_keep_until_deselect;
      @(posedge i_clock) disable iff (!i_rst_n)
      $fell(own_ff.media_tray_select_bit) |->
         $past(i_cmd_valid && !i_cmd_sel.media_tray_select_bit);
   endproperty
   a_keep_until_deselect: assert property (p_keep_until_deselect)
      else $error("media ownership dropped without deselect");

   property p_answer_first;
      @(posedge i_clock) disable iff (!i_rst_n)
      (desel != 2'b00) |=> o_cmd_resp &&
         ((path_ff & $past(desel)) == $past(desel));
   endproperty
   a_answer_first: assert property (p_answer_first)
      else $error("deselect not answered first");

   property p_led_off;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_cmd_valid && own_ff.console_select_bit &&
       !i_cmd_sel.console_select_bit) |=> !o_console_led;
   endproperty
   a_led_off: assert property (p_led_off)
      else $error("console indicator still lit after deselect");

   property p_led_gated;
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_console_led |-> o_console_enable) and
      (o_media_led |-> o_media_enable);
   endproperty
   a_led_gated: assert property (p_led_gated)
      else $error("indicator lit without path");

   property p_report_full;
      @(posedge i_clock) disable iff (!i_rst_n)
      ($rose(o_rpt_valid) && o_rpt.kind == RPT_REQUEST) |->
         (o_rpt.sel & $past(own_ff)) == $past(own_ff) && o_rpt.sel != 2'b00;
   endproperty
   a_report_full: assert property (p_report_full)
      else $error("request report lost current holdings");

   property p_report_steady;
      @(posedge i_clock) disable iff (!i_rst_n)
      (o_rpt_valid && !i_rpt_ack) |=> o_rpt_valid && $stable(o_rpt);
   endproperty
   a_report_steady: assert property (p_report_steady)
      else $error("report changed before acknowledge");

   property p_notice_holdings;
      @(posedge i_clock) disable iff (!i_rst_n)
      ($rose(o_rpt_valid) && o_rpt.kind == RPT_NOTICE) |->
         o_rpt.sel == $past(path_ff);
   endproperty
   a_notice_holdings: assert property (p_notice_holdings)
      else $error("release notice does not show holdings");

   property p_hold_capped;
      @(posedge i_clock) disable iff (!i_rst_n)
      rel_busy_ff |-> rel_cnt_ff <= HOLD_MAX_MS;
   endproperty
   a_hold_capped: assert property (p_hold_capped)
      else $error("release hold exceeds cap");

   property p_owned_press_ignored;
      @(posedge i_clock) disable iff (!i_rst_n)
      $rose(want_ff.console_select_bit) |-> !$past(own_ff.console_select_bit);
   endproperty
   a_owned_press_ignored: assert property (p_owned_press_ignored)
      else $error("press for owned console was requested");

endmodule : csm_top

`default_nettype wire

/* File: core/csm_pkg.sv */
// Purpose: Shared constants and types for the console and media ownership
//          handshake of the blade
// Assumes: 25 MHz system clock, classic Wishbone register slave
// Notes:   Selection bits travel as a packed pair, media above console
`default_nettype none

package csm_pkg;

   // Clock and timing
   localparam int unsigned CLOCK_HZ = 25_000_000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned RELEASE_LIMIT_MS = 8000;
   localparam int unsigned HOLD_MARGIN_MS = 1000;
   localparam logic [12:0] HOLD_MAX_MS =
      13'(RELEASE_LIMIT_MS - HOLD_MARGIN_MS);

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] HOLD_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // Control fields and reset values
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_ENABLE_RST = 1'b1;
   localparam logic [12:0] HOLD_RST = 13'h0000;

   // Status field positions
   localparam int unsigned STAT_OWN_LSB = 0;
   localparam int unsigned STAT_PATH_LSB = 2;
   localparam int unsigned STAT_WANT_LSB = 4;
   localparam int unsigned STAT_RPT_BIT = 6;
   localparam int unsigned STAT_HOLD_BIT = 7;

   // Report kinds carried in the report-type bit
   localparam logic RPT_REQUEST = 1'b0;
   localparam logic RPT_NOTICE = 1'b1;

   // Selection pair, one bit per shared resource
   typedef struct packed {
      logic media_tray_select_bit;
      logic console_select_bit;
   } csm_sel_type;

   // Outgoing blade selection report
   typedef struct packed {
      logic kind;
      csm_sel_type sel;
   } csm_report_type;

   // Report channel states
   typedef enum logic [1:0] {
      RPT_IDLE = 2'b01,
      RPT_SEND = 2'b10
   } csm_rpt_state_type;

endpackage : csm_pkg

`default_nettype wire

/* File: core/csm_button_edge.sv */
// Purpose: Bring one front-panel button into the clock domain and flag presses
// Assumes: Button is a level from a pin, high while pressed
// Notes:   Emits a one-cycle pulse on each press
`default_nettype none

module csm_button_edge
   import csm_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Button pin
   input wire logic i_button,
   // Press pulse
   output logic o_press
);

   logic meta_ff;
   logic sync_ff;
   logic last_ff;
   logic press_ff;
   logic nxt_press;

   // Rising edge of the settled level
   assign nxt_press = sync_ff & ~last_ff;
   assign o_press = press_ff;

   // Two-stage synchroniser, then edge memory
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
         press_ff <= 1'b0;
      end else begin
         meta_ff <= i_button;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
         press_ff <= nxt_press;
      end
   end

endmodule : csm_button_edge

`default_nettype wire

/* File: bench/csm_mgr_model.sv */
// Purpose: Chassis manager stand-in for the console and media handshake
// Assumes: One blade attached; the bench issues commands through send
// Notes:   Acks each report after ack_dly cycles; locked blocks commands
`default_nettype none

module csm_mgr_model
   import csm_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Report side
   input wire logic i_rpt_valid,
   output logic o_rpt_ack,
   // Command side
   output logic o_cmd_valid,
   output csm_sel_type o_cmd_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   int ack_dly = 0;
   logic locked = 1'b0;

   // Idle levels from time zero
   initial begin
      o_rpt_ack = 1'b0;
      o_cmd_valid = 1'b0;
      o_cmd_sel = 2'h0;
   end

   // Answer each outstanding report, promptly or slowly
   always @(posedge i_clock) begin
      if (i_rst_n && i_rpt_valid && !o_rpt_ack) begin
         repeat (ack_dly) @(posedge i_clock);
         o_rpt_ack <= 1'b1;
         @(posedge i_clock);
         o_rpt_ack <= 1'b0;
         repeat (2) @(posedge i_clock);
      end
   end

   // Grant or deselect; a locked switch sends nothing at all
   task send(input csm_sel_type sel);
      if (!locked) begin
         @(posedge i_clock);
         o_cmd_valid <= 1'b1;
         o_cmd_sel <= sel;
         @(posedge i_clock);
         o_cmd_valid <= 1'b0;
         o_cmd_sel <= ~sel;
      end
   endtask : send

endmodule : csm_mgr_model

`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the blade console and media handshake
// Assumes: TICK_LEN cut to 10 cycles so release holds stay short
// Notes:   Driver queues expected replies; a monitor pops and compares
`default_nettype none

module tb_top
   import csm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TL = 10;
   // Manager regrant deadline in scaled cycles
   localparam int LATE = RELEASE_LIMIT_MS * TL;
   logic i_clock;
   logic i_rst_n;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [31:0] wb_dat, wb_rd, rd;
   logic [3:0] wb_sel;
   logic btn_c, btn_m;
   logic rpt_prev = 1'b0;
   logic cmd_valid, cmd_resp, rpt_valid, rpt_ack;
   logic en_c, en_m, led_c, led_m;
   csm_sel_type cmd_sel, resp_sel;
   csm_report_type rpt;
   logic [3:0] q[$];
   logic [15:0] lf = 16'hDF87;
   int bad_count = 0, n_tests = 0, h;
   int unsigned n_cyc = 0, desel_at = 0;

   // Free-running 25 MHz clock
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   csm_top #(.TICK_LEN(TL)) dut (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(wb_cyc),
      .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
      .i_wb_dat(wb_dat), .i_wb_sel(wb_sel), .o_wb_dat(wb_rd),
      .o_wb_ack(wb_ack), .i_console_button(btn_c),
      .i_media_button(btn_m), .i_cmd_valid(cmd_valid),
      .i_cmd_sel(cmd_sel), .o_cmd_resp(cmd_resp), .o_resp_sel(resp_sel),
      .o_rpt_valid(rpt_valid), .o_rpt(rpt), .i_rpt_ack(rpt_ack),
      .o_console_enable(en_c), .o_media_enable(en_m),
      .o_console_led(led_c), .o_media_led(led_m));

   csm_mgr_model mgr (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_rpt_valid(rpt_valid),
      .o_rpt_ack(rpt_ack), .o_cmd_valid(cmd_valid), .o_cmd_sel(cmd_sel));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic check(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask : cyc

   // One classic Wishbone cycle; read data lands in rd
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] s);
      @(posedge i_clock);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= s;
      do @(posedge i_clock); while (!wb_ack);
      rd = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask : wb

   task automatic press(input logic c, input logic m);
      @(posedge i_clock);
      btn_c <= c;
      btn_m <= m;
      cyc(5);
      btn_c <= 1'b0;
      btn_m <= 1'b0;
   endtask : press

   task automatic note(input logic [3:0] v);
      q.push_back(v);
   endtask : note

   // Outputs as {media path, console path, media led, console led}
   task automatic pins(input logic [3:0] e);
      check(32'(e), 32'({en_m, en_c, led_m, led_c}));
   endtask : pins

   // Wait, bounded, until every queued reply has shown up
   task automatic settle;
      int n = 0;
      while ((q.size() != 0 || rpt_valid) && n < 3000) begin
         @(posedge i_clock);
         n++;
      end
      cyc(4);
      check(32'h0, 32'(q.size()));
   endtask : settle

   task automatic take(input logic [3:0] g);
      if (q.size() == 0) check(32'h0000_0010, 32'(g));
      else check(32'(q.pop_front()), 32'(g));
   endtask : take

   // Monitor: command answers and newly raised reports
   always @(posedge i_clock) begin
      n_cyc++;
      if (i_rst_n) begin
         if (cmd_resp) take({2'h0, resp_sel});
         if (rpt_valid && !rpt_prev) take({1'b1, rpt});
         // Release notice must beat the manager's forced regrant
         if (rpt_valid && !rpt_prev && rpt.kind) begin
            check(32'h1, 32'(n_cyc - desel_at <= LATE));
         end
      end
      rpt_prev <= rpt_valid;
   end

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   // Watchdog
   initial begin
      cyc(30000);
      bad_count++;
      summarize;
   end

   // Main sequence
   initial begin
      i_rst_n <= 1'b0;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      wb_adr <= 8'h00;
      wb_dat <= 32'h0000_0000;
      wb_sel <= 4'h0;
      btn_c <= 1'b0;
      btn_m <= 1'b0;
      cyc(16);
      i_rst_n <= 1'b1;
      cyc(2);
      pins(4'h0);
      wb(1'b0, CTRL_OFS, 32'h0, 4'hF);
      check(32'h0000_0001, rd);
      wb(1'b0, HOLD_OFS, 32'h0, 4'hF);
      check(32'h0000_0000, rd);
      wb(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
      wb(1'b0, 8'h0C, 32'h0, 4'hF);
      check(32'h0000_0000, rd);
      // Presses are dropped while disabled
      wb(1'b1, CTRL_OFS, 32'h0, 4'hF);
      press(1'b1, 1'b0);
      settle;
      wb(1'b1, CTRL_OFS, 32'h1, 4'hF);
      lf = lfsr(lf);
      mgr.ack_dly = lf[3:0];
      // Console request, grant after a random wait
      note(4'h9);
      press(1'b1, 1'b0);
      settle;
      pins(4'h0);
      cyc(lf[7:0]);
      note(4'h1);
      mgr.send(2'h1);
      cyc(3);
      pins(4'h5);
      press(1'b1, 1'b0);
      settle;
      pins(4'h5);
      // Media while console held
      note(4'hB);
      press(1'b0, 1'b1);
      settle;
      note(4'h3);
      mgr.send(2'h3);
      cyc(3);
      wb(1'b0, STATUS_OFS, 32'h0, 4'hF);
      check(32'h0000_000F, rd);
      wb(1'b1, HOLD_OFS, 32'h0000_1FFF, 4'h3);
      wb(1'b0, HOLD_OFS, 32'h0, 4'hF);
      check(32'h0000_1B58, rd);
      lf = lfsr(lf);
      mgr.ack_dly = lf[3:0];
      h = 2 + int'(lf[1:0]);
      wb(1'b1, HOLD_OFS, 32'(h), 4'h3);
      // Console deselect under a hold: led off first, path later
      note(4'h2);
      note(4'hE);
      desel_at = n_cyc;
      mgr.send(2'h2);
      cyc(2);
      pins(4'hE);
      cyc((h - 1) * TL - 4);
      pins(4'hE);
      settle;
      pins(4'hA);
      wb(1'b1, HOLD_OFS, 32'h0, 4'h3);
      note(4'h0);
      note(4'hC);
      desel_at = n_cyc;
      mgr.send(2'h0);
      settle;
      pins(4'h0);
      // Both at once, locked, then unlocked and both released
      note(4'hB);
      press(1'b1, 1'b1);
      settle;
      mgr.locked = 1'b1;
      mgr.send(2'h3);
      cyc(200);
      pins(4'h0);
      mgr.locked = 1'b0;
      note(4'h3);
      mgr.send(2'h3);
      cyc(3);
      pins(4'hF);
      note(4'h0);
      note(4'hC);
      desel_at = n_cyc;
      mgr.send(2'h0);
      settle;
      pins(4'h0);
      summarize;
   end

endmodule : tb_top

`default_nettype wire
